// File: logic/tacr_cfg.svh
/*
  Addresses, reset values, field positions and codes of the acquisition
  configuration registers.
  Assumes it is included by its bare name wherever these are needed.
*/
`ifndef TACR_CFG_SVH
`define TACR_CFG_SVH

`define TACR_ADDR_SAMPLE_MODE 8'h92
`define TACR_ADDR_READOUT 8'h95
`define TACR_ADDR_MULT_HI 8'ha0
`define TACR_ADDR_MULT_LO 8'ha1
`define TACR_ADDR_LEN_HI 8'ha2
`define TACR_ADDR_LEN_LO 8'ha3
`define TACR_ADDR_DELAY 8'hae

`define TACR_RST_SAMPLE_MODE 8'h30
`define TACR_RST_READOUT 8'h23
`define TACR_RST_MULT_HI 8'h00
`define TACR_RST_MULT_LO 8'h01
`define TACR_RST_LEN_HI 8'h00
`define TACR_RST_LEN_LO 8'h01
`define TACR_RST_DELAY 8'h01

`define TACR_F_ROWSEL 1:0
`define TACR_F_INTSEL 3:2
`define TACR_F_COUNT 5:4
`define TACR_F_MOD 7:6
`define TACR_F_PIXEL 4:2
`define TACR_B_FORMAT 5
`define TACR_B_RAW 6
`define TACR_MULT_HI_BITS 1:0

`define TACR_DELAY_NONE 8'h01
`define TACR_DELAY_MANUAL 8'h04

`define TACR_SAMPLE_MID 12'h0800
`define TACR_B_SAT 12
`define TACR_B_OVF 13
`define TACR_B_UNF 14

`endif

// File: logic/tacr_pkg.sv
/*
  Types of the acquisition configuration block: decoded modes and the
  configuration bundle handed to the acquisition sequencer.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package tacr_pkg;

  typedef enum logic [1:0] {
    tacr_samples_one,
    tacr_samples_two,
    tacr_samples_four,
    tacr_samples_bad
  } tacr_samples_e;

  typedef enum logic [1:0] {
    tacr_tof_imager_mode,
    tacr_grayscale_imager_mode,
    tacr_mod_bad
  } tacr_mod_e;

  typedef enum logic [2:0] {
    tacr_pix_full,
    tacr_pix_full_sum_low_noise,
    tacr_pix_center_quad_fast,
    tacr_pix_row_sum_multi_integration,
    tacr_pix_binned_grayscale,
    tacr_pix_bad
  } tacr_pix_e;

  typedef enum logic [1:0] {
    tacr_delay_none,
    tacr_delay_manual,
    tacr_delay_bad
  } tacr_delay_e;

  typedef struct packed {
    logic rows_same_sample;
    logic integ_per_row;
    tacr_samples_e samples;
    tacr_mod_e modulation;
    tacr_pix_e pixel_field;
    logic signed_format;
    logic embed_flags;
    logic [9:0] multiplier;
    logic [15:0] integ_length;
    tacr_delay_e delay_mode;
    logic reserved_code;
  } tacr_cfg_s;

  typedef struct packed {
    logic [11:0] value;
    logic saturated;
    logic overflow;
    logic underflow;
  } tacr_sample_s;

endpackage : tacr_pkg

`default_nettype wire

// File: logic/tacr_regs.sv
/*
  Acquisition configuration registers of the time-of-flight sensor, their
  decoded modes, and the output word formatter that those modes steer.
  Assumes the serial port engine, on the same clock, presents one decoded
  byte access per cycle: address, write strobe with data, read strobe.
  Per-row integration lengths live elsewhere and are presented as an input.
*/
// Function
// - Row-select code 00 applies the same correlation sample to all rows.
// - Integration-select 00 uses the single 16-bit length for all rows.
// - Integration-select 10 uses per-row lengths; 01 and 11 reserved.
// - Readout count 00 gives one sample, 01 gives two samples.
// - Readout count 11 gives all four correlation samples; 10 reserved.
// - Modulation 00 is time-of-flight, 11 grayscale; 01 and 10 reserved.
// - Pixel code picks full, 64-sum, centre-4, row-sum or binned readout.
// - Readout bit 5 picks unsigned or two's complement; default signed.
// - Readout bit 6 low embeds validity flags; high outputs raw data.
// - Ten-bit multiplier across two byte registers, resetting to one.
// - 16-bit integration length over two registers, used in single mode.
// - Delay control 0x01 means no delay, 0x04 manual delay step.
// - Sample-mode register at 0x92, read/write, resets to 0x30.
`include "tacr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tacr_regs (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  output logic reg_rvalid, // Read data valid pulse
  input wire logic [15:0] row_length, // Current row's own integration length
  output var tacr_pkg::tacr_cfg_s cfg, // Decoded configuration
  output logic [15:0] active_length, // Integration length in force
  input wire logic smp_valid, // Converter sample strobe
  input wire tacr_pkg::tacr_sample_s smp_in, // Converter sample, offset binary
  output logic out_valid, // Formatted word strobe
  output logic [15:0] out_word // Formatted data word
);

  logic [7:0] sample_mode, next_sample_mode;
  logic [7:0] readout, next_readout;
  logic [7:0] mult_hi, next_mult_hi;
  logic [7:0] mult_lo, next_mult_lo;
  logic [7:0] len_hi, next_len_hi;
  logic [7:0] len_lo, next_len_lo;
  logic [7:0] delay_ctl, next_delay_ctl;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_out_valid;
  logic [15:0] next_out_word;
  logic [11:0] signed_val;
  logic [11:0] data_val;

  // Register writes and read mux
  always_comb begin
    next_sample_mode = sample_mode;
    next_readout = readout;
    next_mult_hi = mult_hi;
    next_mult_lo = mult_lo;
    next_len_hi = len_hi;
    next_len_lo = len_lo;
    next_delay_ctl = delay_ctl;
    if (reg_wr) begin
      if (reg_addr == `TACR_ADDR_SAMPLE_MODE) begin
        next_sample_mode = reg_wdata;
      end else if (reg_addr == `TACR_ADDR_READOUT) begin
        next_readout = reg_wdata;
      end else if (reg_addr == `TACR_ADDR_MULT_HI) begin
        next_mult_hi = reg_wdata;
      end else if (reg_addr == `TACR_ADDR_MULT_LO) begin
        next_mult_lo = reg_wdata;
      end else if (reg_addr == `TACR_ADDR_LEN_HI) begin
        next_len_hi = reg_wdata;
      end else if (reg_addr == `TACR_ADDR_LEN_LO) begin
        next_len_lo = reg_wdata;
      end else if (reg_addr == `TACR_ADDR_DELAY) begin
        next_delay_ctl = reg_wdata;
      end
    end
    next_rvalid = reg_rd;
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `TACR_ADDR_SAMPLE_MODE) begin
        next_rdata = sample_mode;
      end else if (reg_addr == `TACR_ADDR_READOUT) begin
        next_rdata = readout;
      end else if (reg_addr == `TACR_ADDR_MULT_HI) begin
        next_rdata = mult_hi;
      end else if (reg_addr == `TACR_ADDR_MULT_LO) begin
        next_rdata = mult_lo;
      end else if (reg_addr == `TACR_ADDR_LEN_HI) begin
        next_rdata = len_hi;
      end else if (reg_addr == `TACR_ADDR_LEN_LO) begin
        next_rdata = len_lo;
      end else if (reg_addr == `TACR_ADDR_DELAY) begin
        next_rdata = delay_ctl;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sample_mode <= `TACR_RST_SAMPLE_MODE;
      readout <= `TACR_RST_READOUT;
      mult_hi <= `TACR_RST_MULT_HI;
      mult_lo <= `TACR_RST_MULT_LO;
      len_hi <= `TACR_RST_LEN_HI;
      len_lo <= `TACR_RST_LEN_LO;
      delay_ctl <= `TACR_RST_DELAY;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      sample_mode <= next_sample_mode;
      readout <= next_readout;
      mult_hi <= next_mult_hi;
      mult_lo <= next_mult_lo;
      len_hi <= next_len_hi;
      len_lo <= next_len_lo;
      delay_ctl <= next_delay_ctl;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // Mode decode; reserved codes raise reserved_code
  always_comb begin
    cfg = '0;
    cfg.rows_same_sample = (sample_mode[`TACR_F_ROWSEL] == 2'b00);
    cfg.integ_per_row = (sample_mode[`TACR_F_INTSEL] == 2'b10);
    case (sample_mode[`TACR_F_COUNT])
      2'b00: cfg.samples = tacr_pkg::tacr_samples_one;
      2'b01: cfg.samples = tacr_pkg::tacr_samples_two;
      2'b11: cfg.samples = tacr_pkg::tacr_samples_four;
      default: cfg.samples = tacr_pkg::tacr_samples_bad;
    endcase
    case (sample_mode[`TACR_F_MOD])
      2'b00: cfg.modulation = tacr_pkg::tacr_tof_imager_mode;
      2'b11: cfg.modulation = tacr_pkg::tacr_grayscale_imager_mode;
      default: cfg.modulation = tacr_pkg::tacr_mod_bad;
    endcase
    case (readout[`TACR_F_PIXEL])
      3'b000: cfg.pixel_field = tacr_pkg::tacr_pix_full;
      3'b001: cfg.pixel_field = tacr_pkg::tacr_pix_full_sum_low_noise;
      3'b010: cfg.pixel_field = tacr_pkg::tacr_pix_center_quad_fast;
      3'b011: cfg.pixel_field =
        tacr_pkg::tacr_pix_row_sum_multi_integration;
      3'b101: cfg.pixel_field = tacr_pkg::tacr_pix_binned_grayscale;
      default: cfg.pixel_field = tacr_pkg::tacr_pix_bad;
    endcase
    cfg.signed_format = readout[`TACR_B_FORMAT];
    cfg.embed_flags = !readout[`TACR_B_RAW];
    cfg.multiplier = {mult_hi[`TACR_MULT_HI_BITS], mult_lo};
    cfg.integ_length = {len_hi, len_lo};
    case (delay_ctl)
      `TACR_DELAY_NONE: cfg.delay_mode = tacr_pkg::tacr_delay_none;
      `TACR_DELAY_MANUAL: cfg.delay_mode = tacr_pkg::tacr_delay_manual;
      default: cfg.delay_mode = tacr_pkg::tacr_delay_bad;
    endcase
    cfg.reserved_code = (sample_mode[`TACR_F_ROWSEL] != 2'b00)
      || (sample_mode[`TACR_F_INTSEL] == 2'b01)
      || (sample_mode[`TACR_F_INTSEL] == 2'b11)
      || (cfg.samples == tacr_pkg::tacr_samples_bad)
      || (cfg.modulation == tacr_pkg::tacr_mod_bad)
      || (cfg.pixel_field == tacr_pkg::tacr_pix_bad)
      || (cfg.delay_mode == tacr_pkg::tacr_delay_bad);
  end

  // Single length unless per-row mode is chosen
  always_comb begin
    if (cfg.integ_per_row) begin
      active_length = row_length;
    end else begin
      active_length = cfg.integ_length;
    end
  end

  // Output word formatter
  always_comb begin
    signed_val = smp_in.value - `TACR_SAMPLE_MID;
    data_val = cfg.signed_format ? signed_val : smp_in.value;
    next_out_valid = smp_valid;
    next_out_word = out_word;
    if (smp_valid) begin
      next_out_word = {{4{cfg.signed_format & data_val[11]}}, data_val};
      if (cfg.embed_flags) begin
        next_out_word[`TACR_B_SAT] = smp_in.saturated;
        next_out_word[`TACR_B_OVF] = smp_in.overflow;
        next_out_word[`TACR_B_UNF] = smp_in.underflow;
        next_out_word[15] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_word <= 16'h0000;
    end else begin
      out_valid <= next_out_valid;
      out_word <= next_out_word;
    end
  end

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  reset_value_a: assert property ($rose(rst_n) |->
    cfg.samples == tacr_pkg::tacr_samples_four && cfg.signed_format
    && cfg.embed_flags && cfg.multiplier == 10'h001
    && cfg.integ_length == 16'h0001)
    else $error("Configuration not at reset values");
  sample_mode_rw_a: assert property (
    (reg_wr && reg_addr == `TACR_ADDR_SAMPLE_MODE)
    ##1 (reg_rd && !reg_wr && reg_addr == `TACR_ADDR_SAMPLE_MODE)
    |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("Sample-mode readback differs from write");
  rows_same_a: assert property (
    cfg.rows_same_sample == !(sample_mode[1] || sample_mode[0]))
    else $error("Row select decode wrong");
  single_len_a: assert property (sample_mode[3:2] == 2'b00
    |-> active_length == {len_hi, len_lo})
    else $error("Single integration length not used");
  per_row_len_a: assert property (sample_mode[3:2] == 2'b10
    |-> active_length == row_length)
    else $error("Per-row integration length not used");
  count_two_a: assert property (sample_mode[5:4] == 2'b01
    |-> cfg.samples == tacr_pkg::tacr_samples_two)
    else $error("Two-sample count decode wrong");
  count_four_a: assert property (sample_mode[5:4] == 2'b11
    |-> cfg.samples == tacr_pkg::tacr_samples_four)
    else $error("Four-sample count decode wrong");
  gray_mode_a: assert property (sample_mode[7:6] == 2'b11
    |-> cfg.modulation == tacr_pkg::tacr_grayscale_imager_mode)
    else $error("Grayscale decode wrong");
  binned_a: assert property (readout[4:2] == 3'b101
    |-> cfg.pixel_field == tacr_pkg::tacr_pix_binned_grayscale)
    else $error("Binned readout decode wrong");
  signed_word_a: assert property (smp_valid && readout[5] && readout[6]
    |=> out_valid && out_word == {{4{$past(smp_in.value[11]) ^ 1'b1}},
    $past(smp_in.value) ^ 12'h800})
    else $error("Signed raw word wrong");
  embed_flag_a: assert property (smp_valid && !readout[6]
    |=> out_word[`TACR_B_SAT] == $past(smp_in.saturated)
    && out_word[`TACR_B_UNF] == $past(smp_in.underflow))
    else $error("Validity flags not embedded");
  mult_write_a: assert property (reg_wr
    && reg_addr == `TACR_ADDR_MULT_HI
    |=> cfg.multiplier[9:8] == $past(reg_wdata[1:0]))
    else $error("Multiplier high bits not taken");
  delay_manual_a: assert property (reg_wr
    && reg_addr == `TACR_ADDR_DELAY && reg_wdata == 8'h04
    |=> cfg.delay_mode == tacr_pkg::tacr_delay_manual)
    else $error("Manual delay not selected");

  per_row_c: cover property (sample_mode[3:2] == 2'b10 && smp_valid);
  gray_c: cover property (cfg.modulation
    == tacr_pkg::tacr_grayscale_imager_mode ##1 out_valid);
  raw_unsigned_c: cover property (!readout[5] && readout[6] && out_valid);
  reserved_c: cover property (cfg.reserved_code);

endmodule : tacr_regs

`default_nettype wire

// File: sim/tacr_host.sv
/*
  Host model: drives byte accesses onto the register port of the
  acquisition configuration block, changing signals at the falling edge.
  Assumes one clock, shared with the block, and a read answer that arrives
  within eight cycles of the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module tacr_host (
  input wire logic clk_sys, // System clock
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr, // Write strobe
  output logic [7:0] reg_wdata, // Write data
  output logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid // Read data valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Callers may pass reserved bits and codes away from their defaults
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // Released data no longer shows the last byte
    reg_wdata = ~d;
  endtask : wr

  // Write, then read the same address in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_wdata = ~d;
    ok = (reg_rvalid === 1'b1);
    q = reg_rdata;
  endtask : wr_rd

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 8 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask : rd
endmodule : tacr_host

`default_nettype wire

// File: sim/tacr_regs_tb.sv
/*
  Self-checking testbench of the acquisition configuration registers.
  Assumes a 20 MHz clock, synchronous active-low reset, and the host model
  for all register traffic.
*/
`timescale 1ns/1ps
`default_nettype none

module tacr_regs_tb;
  logic clk_sys;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [15:0] row_length;
  tacr_pkg::tacr_cfg_s cfg;
  logic [15:0] active_length;
  logic smp_valid;
  tacr_pkg::tacr_sample_s smp_in;
  logic out_valid;
  logic [15:0] out_word;
  int errors;
  int comparisons;

  tacr_regs tacr_regs_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .row_length(row_length), .cfg(cfg), .active_length(active_length),
    .smp_valid(smp_valid), .smp_in(smp_in), .out_valid(out_valid),
    .out_word(out_word));

  tacr_host tacr_host_i (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    tacr_host_i.rd(a, d, ok);
    if (!ok) begin
      errors++;
      $display("Error at %0t ns: read timeout %h expected %h", $time, a, exp);
      test_done();
    end else begin
      chk({8'h00, d}, {8'h00, exp});
    end
  endtask : rdchk

  task automatic test_reset();
    logic [7:0] ra [7];
    logic [7:0] rv [7];
    ra = '{8'h92, 8'h95, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'hae};
    rv = '{8'h30, 8'h23, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01};
    for (int i = 0; i < 7; i++) rdchk(ra[i], rv[i]);
    rdchk(8'h93, 8'h00);
    chk(cfg.rows_same_sample, 16'h0001);
    chk(cfg.samples, tacr_pkg::tacr_samples_four);
    chk(cfg.modulation, tacr_pkg::tacr_tof_imager_mode);
    chk(cfg.pixel_field, tacr_pkg::tacr_pix_full);
    chk(cfg.signed_format, 16'h0001);
    chk(cfg.embed_flags, 16'h0001);
    chk(cfg.multiplier, 16'h0001);
    chk(active_length, 16'h0001);
    chk(cfg.delay_mode, tacr_pkg::tacr_delay_none);
    chk(cfg.reserved_code, 16'h0000);
    $display("Test reset values done");
  endtask : test_reset

  task automatic test_sample_mode();
    logic [7:0] v [6];
    tacr_pkg::tacr_samples_e s [6];
    logic [15:0] al [6];
    tacr_pkg::tacr_mod_e md;
    logic [7:0] d;
    logic ok;
    v = '{8'h00, 8'h10, 8'hc8, 8'h20, 8'h31, 8'h70};
    s = '{tacr_pkg::tacr_samples_one, tacr_pkg::tacr_samples_two,
          tacr_pkg::tacr_samples_one, tacr_pkg::tacr_samples_bad,
          tacr_pkg::tacr_samples_four, tacr_pkg::tacr_samples_four};
    al = '{16'h0001, 16'h0001, 16'hbeef, 16'h0001, 16'h0001, 16'h0001};
    for (int i = 0; i < 6; i++) begin
      md = tacr_pkg::tacr_mod_bad;
      if (v[i][7:6] == 2'b00) begin
        md = tacr_pkg::tacr_tof_imager_mode;
      end else if (v[i][7:6] == 2'b11) begin
        md = tacr_pkg::tacr_grayscale_imager_mode;
      end
      tacr_host_i.wr(8'h92, v[i]);
      chk(cfg.samples, s[i]);
      chk(active_length, al[i]);
      chk(cfg.integ_per_row, {15'h0000, v[i][3]});
      chk(cfg.rows_same_sample, {15'h0000, v[i][1:0] == 2'b00});
      chk(cfg.modulation, md);
      chk(cfg.reserved_code, {15'h0000, i >= 3});
      rdchk(8'h92, v[i]);
    end
    // Back-to-back write and read of the same register
    tacr_host_i.wr_rd(8'h92, 8'h30, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk({8'h00, d}, 16'h0030);
    $display("Test sample mode done");
  endtask : test_sample_mode

  task automatic test_pixel();
    logic [2:0] c [5];
    tacr_pkg::tacr_pix_e p [5];
    c = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b101};
    p = '{tacr_pkg::tacr_pix_full, tacr_pkg::tacr_pix_full_sum_low_noise,
          tacr_pkg::tacr_pix_center_quad_fast,
          tacr_pkg::tacr_pix_row_sum_multi_integration,
          tacr_pkg::tacr_pix_binned_grayscale};
    for (int i = 0; i < 5; i++) begin
      tacr_host_i.wr(8'h95, {3'b001, c[i], 2'b11});
      chk(cfg.pixel_field, p[i]);
    end
    tacr_host_i.wr(8'h95, 8'h33);
    chk(cfg.pixel_field, tacr_pkg::tacr_pix_bad);
    chk(cfg.reserved_code, 16'h0001);
    tacr_host_i.wr(8'h95, 8'h23);
    $display("Test pixel field done");
  endtask : test_pixel

  task automatic test_lengths();
    tacr_host_i.wr(8'ha2, 8'h12);
    tacr_host_i.wr(8'ha3, 8'h34);
    chk(active_length, 16'h1234);
    chk(cfg.integ_length, 16'h1234);
    tacr_host_i.wr(8'ha0, 8'hff);
    tacr_host_i.wr(8'ha1, 8'h5a);
    chk(cfg.multiplier, 16'h035a);
    tacr_host_i.wr(8'hae, 8'h04);
    chk(cfg.delay_mode, tacr_pkg::tacr_delay_manual);
    tacr_host_i.wr(8'hae, 8'h02);
    chk(cfg.delay_mode, tacr_pkg::tacr_delay_bad);
    chk(cfg.reserved_code, 16'h0001);
    tacr_host_i.wr(8'hae, 8'h01);
    chk(cfg.delay_mode, tacr_pkg::tacr_delay_none);
    $display("Test lengths and delay done");
  endtask : test_lengths

  task automatic test_format();
    logic [7:0] m [5];
    tacr_pkg::tacr_sample_s x [5];
    logic [15:0] e [5];
    m = '{8'h23, 8'h23, 8'h03, 8'h63, 8'h43};
    x = '{'{12'h801, 1'b1, 1'b0, 1'b0}, '{12'h7ff, 1'b0, 1'b1, 1'b1},
          '{12'h7ff, 1'b1, 1'b0, 1'b0}, '{12'h7ff, 1'b1, 1'b1, 1'b1},
          '{12'hfff, 1'b1, 1'b0, 1'b0}};
    e = '{16'h1001, 16'h6fff, 16'h17ff, 16'hffff, 16'h0fff};
    for (int i = 0; i < 5; i++) begin
      tacr_host_i.wr(8'h95, m[i]);
      @(negedge clk_sys);
      smp_in = x[i];
      smp_valid = 1'b1;
      @(negedge clk_sys);
      smp_valid = 1'b0;
      smp_in = ~x[i];
      chk(out_valid, 16'h0001);
      chk(out_word, e[i]);
    end
    $display("Test output format done");
  endtask : test_format

  initial begin
    errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    row_length = 16'hbeef;
    smp_valid = 1'b0;
    smp_in = '0;
    repeat (21) @(negedge clk_sys);
    rst_n = 1'b1;
    test_reset();
    test_sample_mode();
    test_pixel();
    test_lengths();
    test_format();
    test_done();
  end
endmodule : tacr_regs_tb

`default_nettype wire
